// ===== design/cpd_consts.vh
// Shared constants for the parcel instruction decoder: word layout,
// designator fields, opcode codes and reset values.
// Assumes inclusion by bare name from design files only.
`ifndef CPD_CONSTS_VH
`define CPD_CONSTS_VH

`define CPD_WORD_W 60
`define CPD_PARCEL_W 15
`define CPD_PARCELS 4
`define CPD_K_W 18
`define CPD_OP_MSB 14
`define CPD_OP_LSB 9
`define CPD_I_LSB 6
`define CPD_J_LSB 3
`define CPD_K_LSB 0

// Opcode codes (six-bit, octal)
`define CPD_OP_STOP 6'o00
`define CPD_OP_RJ_GROUP 6'o01
`define CPD_OP_PASS_GROUP 6'o46
`define CPD_OP_SB_FIRST 6'o60
`define CPD_OP_SB_LAST 6'o62
// Upper octal digit groups with two-parcel K forms; jump from code 02 up and code 01 with i below 4, the others in their low three codes
`define CPD_GRP_JUMP 3'o0
`define CPD_GRP_ADDR 3'o5
`define CPD_GRP_INDEX 3'o6
`define CPD_GRP_OPND 3'o7
`define CPD_KFORM_LAST 3'd2

// Register set selects on the write port
`define CPD_SET_A 2'h0
`define CPD_SET_B 2'h1
`define CPD_SET_X 2'h2

`define CPD_PTR_RST 2'h0
`define CPD_LEN_ONE 3'h1
`define CPD_LEN_TWO 3'h2
`define CPD_LEN_FOUR 3'h4

`endif

// ===== design/cpd_sync.v
// Two-flop synchroniser for slow level inputs such as panel switches.
// Assumes levels held far longer than a clock period.
`timescale 1ns/1ps
module cpd_sync #(
  parameter WIDTH = 2
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  genvar b;
  generate
    for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
      always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          meta_q[b] <= 1'b0;
          sync_q[b] <= 1'b0;
        end else begin
          meta_q[b] <= i_async[b];
          sync_q[b] <= meta_q[b];
        end
      end
    end
  endgenerate

  assign o_sync = sync_q;
endmodule

// ===== design/cpd_regfile.v
// Address, index and operand register sets with one write port.
// Assumes the execute units own the write port; reads are combinational.
`timescale 1ns/1ps
module cpd_regfile #(
  parameter AW = 18,
  parameter XW = 60
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_wr_en,
  input wire [1:0] i_wr_set,
  input wire [2:0] i_wr_addr,
  input wire [XW-1:0] i_wr_data,
  input wire [2:0] i_rd_j,
  input wire [2:0] i_rd_k,
  output wire [AW-1:0] o_aj,
  output wire [AW-1:0] o_bj,
  output wire [XW-1:0] o_xj,
  output wire [XW-1:0] o_xk
);
  `include "cpd_consts.vh"

  reg [AW-1:0] a_mem [0:7];
  reg [AW-1:0] b_mem [0:7];
  reg [XW-1:0] x_mem [0:7];

  // One write slot per entry across the three sets
  genvar e;
  generate
    for (e = 0; e < 8; e = e + 1) begin : g_ent
      always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          a_mem[e] <= {AW{1'b0}};
          b_mem[e] <= {AW{1'b0}};
          x_mem[e] <= {XW{1'b0}};
        end else if (i_wr_en && i_wr_addr == e) begin
          if (i_wr_set == `CPD_SET_A) a_mem[e] <= i_wr_data[AW-1:0];
          if (i_wr_set == `CPD_SET_B) b_mem[e] <= i_wr_data[AW-1:0];
          if (i_wr_set == `CPD_SET_X) x_mem[e] <= i_wr_data;
        end
      end
    end
  endgenerate

  // Index zero is forced at the read so a stray write cannot leak out
  assign o_aj = a_mem[i_rd_j];
  assign o_bj = (i_rd_j == 3'h0) ? {AW{1'b0}} : b_mem[i_rd_j];
  assign o_xj = x_mem[i_rd_j];
  assign o_xk = x_mem[i_rd_k];
endmodule

// ===== design/cpd_decoder.v
// Parcel decoder: splits program words into parcels, decodes format and
// designators, hands one instruction at a time to the issue side.
// Assumes fetch gives one word per handshake and the execute side
// reports taken branches as one-cycle pulses on the same clock.
`timescale 1ns/1ps
module cpd_decoder (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_wide_variant,
  input wire i_exchange_jump_enable_switch,
  input wire i_word_valid,
  input wire [59:0] i_word,
  input wire i_branch_taken,
  input wire i_issue_ready,
  input wire i_wr_en,
  input wire [1:0] i_wr_set,
  input wire [2:0] i_wr_addr,
  input wire [59:0] i_wr_data,
  output reg o_word_ready,
  output reg o_instr_valid,
  output reg [5:0] o_opcode_six_bit,
  output reg [8:0] o_opcode_nine_bit,
  output reg [2:0] o_i,
  output reg [2:0] o_j,
  output reg [2:0] o_k,
  output reg [5:0] o_shift_or_mask_count,
  output reg [17:0] o_k18,
  output reg [2:0] o_length,
  output reg [1:0] o_parcel,
  output reg o_fixed_time,
  output reg o_pass,
  output reg o_error_exit,
  output reg o_halt,
  output reg [17:0] o_aj_data,
  output reg [17:0] o_bj_data,
  output reg [59:0] o_xj_data,
  output reg [59:0] o_xk_data
);
  `include "cpd_consts.vh"

  localparam [3:0] S_NEED = 4'h1;
  localparam [3:0] S_DEC = 4'h2;
  localparam [3:0] S_ISSUE = 4'h4;
  localparam [3:0] S_HALT = 4'h8;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [59:0] word_q;
  reg [1:0] ptr_q;
  reg [1:0] ptr_d;
  reg done_q;
  reg done_d;

  wire wide;
  wire xj_en;
  wire [17:0] rf_aj;
  wire [17:0] rf_bj;
  wire [59:0] rf_xj;
  wire [59:0] rf_xk;

  // Switch and variant strap come from the panel, so they are resynchronised
  cpd_sync #(
    .WIDTH(2)
  ) u_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_async({i_wide_variant, i_exchange_jump_enable_switch}),
    .o_sync({wide, xj_en})
  );

  // Parcel table; slot 4 is the all-zero parcel past the word's end
  wire [14:0] parcel [0:4];
  genvar p;
  generate
    for (p = 0; p < `CPD_PARCELS; p = p + 1) begin : g_parcel
      assign parcel[p] = word_q[`CPD_WORD_W-1-p*`CPD_PARCEL_W -: `CPD_PARCEL_W];
    end
  endgenerate
  assign parcel[4] = 15'h0000;

  wire [14:0] cur = parcel[ptr_q];
  wire [2:0] ptr_next = {1'b0, ptr_q} + 3'h1;
  // A second parcel past parcel 3 reads as zero instead of the next word
  wire [14:0] nxt = parcel[ptr_next];
  wire [5:0] op6 = cur[`CPD_OP_MSB:`CPD_OP_LSB];
  wire [2:0] di = cur[`CPD_I_LSB+2:`CPD_I_LSB];
  wire [2:0] dj = cur[`CPD_J_LSB+2:`CPD_J_LSB];
  wire [2:0] dk = cur[`CPD_K_LSB+2:`CPD_K_LSB];

  // Operands are read by the designators of the parcel being decoded
  cpd_regfile #(
    .AW(18),
    .XW(60)
  ) u_regs (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_wr_en(i_wr_en),
    .i_wr_set(i_wr_set),
    .i_wr_addr(i_wr_addr),
    .i_wr_data(i_wr_data),
    .i_rd_j(dj),
    .i_rd_k(dk),
    .o_aj(rf_aj),
    .o_bj(rf_bj),
    .o_xj(rf_xj),
    .o_xk(rf_xk)
  );

  // Format decode: length, pass, stop and illegal placement
  reg [2:0] len;
  reg is_pass;
  reg is_stop;
  reg illegal;
  reg fixed;
  always @* begin
    len = `CPD_LEN_ONE;
    is_pass = 1'b0;
    is_stop = (op6 == `CPD_OP_STOP);
    illegal = 1'b0;
    fixed = 1'b1;
    case (op6[5:3])
      `CPD_GRP_JUMP: begin
        fixed = 1'b0;
        if (op6 == `CPD_OP_RJ_GROUP) begin
          if (!di[2]) len = `CPD_LEN_TWO;
        end else if (op6 != `CPD_OP_STOP) begin
          len = `CPD_LEN_TWO;
        end
      end
      `CPD_GRP_ADDR: begin
        fixed = 1'b0;
        if (op6[2:0] <= `CPD_KFORM_LAST) len = `CPD_LEN_TWO;
      end
      `CPD_GRP_INDEX, `CPD_GRP_OPND: begin
        if (op6[2:0] <= `CPD_KFORM_LAST) len = `CPD_LEN_TWO;
      end
      default: begin
      end
    endcase
    if (op6 == `CPD_OP_PASS_GROUP) begin
      if (!wide || !di[2]) begin
        is_pass = 1'b1;
      end else begin
        len = `CPD_LEN_FOUR;
        illegal = (ptr_q != `CPD_PTR_RST);
      end
    end
    if (op6 >= `CPD_OP_SB_FIRST && op6 <= `CPD_OP_SB_LAST && di == 3'h0) begin
      is_pass = 1'b1;
    end
  end

  // Where the pointer goes and whether the word is used up
  wire [2:0] end_pos = {1'b0, ptr_q} + len;
  wire word_end = (end_pos >= 3'h4);

  // Next-state logic
  always @* begin
    state_d = state_q;
    ptr_d = ptr_q;
    done_d = done_q;
    case (state_q)
      S_NEED: begin
        if (i_word_valid && o_word_ready) begin
          state_d = S_DEC;
          ptr_d = `CPD_PTR_RST;
          done_d = 1'b0;
        end
      end
      S_DEC: begin
        if (i_branch_taken) begin
          state_d = S_NEED;
        end else if (is_stop && wide && !xj_en) begin
          state_d = S_HALT;
        end else if (is_stop || illegal) begin
          state_d = S_NEED;
        end else begin
          ptr_d = end_pos[1:0];
          done_d = word_end;
          if (!is_pass) state_d = S_ISSUE;
          else if (word_end) state_d = S_NEED;
        end
      end
      S_ISSUE: begin
        if (i_branch_taken) state_d = S_NEED;
        else if (i_issue_ready) state_d = done_q ? S_NEED : S_DEC;
      end
      S_HALT: begin
        state_d = S_HALT;
      end
      default: begin
        state_d = S_NEED;
      end
    endcase
  end

  // State, word capture and pointer
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= S_NEED;
      word_q <= 60'h0;
      ptr_q <= `CPD_PTR_RST;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      done_q <= done_d;
      if (state_q == S_NEED && i_word_valid && o_word_ready) word_q <= i_word;
    end
  end

  // Fetch handshake: ready only while waiting for a word
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_word_ready <= 1'b0;
    end else begin
      o_word_ready <= (state_d == S_NEED);
    end
  end

  // Decoded fields are latched once per instruction and held through issue
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_instr_valid <= 1'b0;
      o_opcode_six_bit <= 6'h00;
      o_opcode_nine_bit <= 9'h000;
      o_i <= 3'h0;
      o_j <= 3'h0;
      o_k <= 3'h0;
      o_shift_or_mask_count <= 6'h00;
      o_k18 <= 18'h00000;
      o_length <= 3'h0;
      o_parcel <= 2'h0;
      o_fixed_time <= 1'b0;
      o_aj_data <= 18'h00000;
      o_bj_data <= 18'h00000;
      o_xj_data <= 60'h0;
      o_xk_data <= 60'h0;
    end else begin
      o_instr_valid <= (state_d == S_ISSUE);
      if (state_q == S_DEC && !i_branch_taken) begin
        o_opcode_six_bit <= op6;
        o_opcode_nine_bit <= {op6, di};
        // Stop ignores its designators; one-parcel forms carry no K
        o_i <= is_stop ? 3'h0 : di;
        o_j <= is_stop ? 3'h0 : dj;
        o_k <= is_stop ? 3'h0 : dk;
        o_shift_or_mask_count <= is_stop ? 6'h00 : {dj, dk};
        o_k18 <= (len == `CPD_LEN_ONE) ? 18'h00000 : {dk, nxt};
        o_length <= len;
        o_parcel <= ptr_q;
        o_fixed_time <= fixed;
        o_aj_data <= rf_aj;
        o_bj_data <= rf_bj;
        o_xj_data <= rf_xj;
        o_xk_data <= rf_xk;
      end
    end
  end

  // One-cycle event pulses and the sticky halt
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pass <= 1'b0;
      o_error_exit <= 1'b0;
      o_halt <= 1'b0;
    end else begin
      o_pass <= (state_q == S_DEC) && !i_branch_taken && is_pass && !is_stop;
      // Error exit drops the rest of the word; the fetch side owns the counter
      o_error_exit <= (state_q == S_DEC) && !i_branch_taken &&
                      ((is_stop && !(wide && !xj_en)) || illegal);
      // Halt holds until reset; the counter value is left to fetch
      o_halt <= (state_d == S_HALT);
    end
  end
endmodule

// ===== testbench/cpd_fetch_model.sv
// Fetch-side model: offers queued program words, one per handshake.
// Assumes the bench fills the queue through push after reset.
`timescale 1ns/1ps
module cpd_fetch_model (
  input wire i_clk,
  input wire i_word_ready,
  output logic o_word_valid,
  output logic [59:0] o_word
);
  logic [59:0] q[$];
  task automatic push(input logic [59:0] w);
    q.push_back(w);
  endtask
  initial begin
    o_word_valid = 1'b0;
    o_word = 60'h0;
  end
  // Word held until taken; a released bus shows the inverse, never the old word
  always @(posedge i_clk) begin
    if (o_word_valid && i_word_ready) begin
      o_word_valid <= 1'b0;
      o_word <= ~o_word;
    end else if (!o_word_valid && q.size() > 0) begin
      o_word <= q.pop_front();
      o_word_valid <= 1'b1;
    end
  end
endmodule

// ===== testbench/cpd_checker.sv
// Checker: port timing relations of the parcel decoder.
// Assumes a bind into the decoder; sees its ports only.
`timescale 1ns/1ps
module cpd_checker (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_word_valid,
  input wire i_branch_taken,
  input wire i_issue_ready,
  input wire o_word_ready,
  input wire o_instr_valid,
  input wire [2:0] o_j,
  input wire [2:0] o_k,
  input wire [5:0] o_shift_or_mask_count,
  input wire [17:0] o_k18,
  input wire [2:0] o_length,
  input wire [1:0] o_parcel,
  input wire o_pass,
  input wire o_error_exit,
  input wire o_halt
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // A taken word yields a result two edges on, halt included; the check allows one edge more
  sequence s_take;
    i_word_valid && o_word_ready;
  endsequence
  sequence s_answer;
    ##[2:3] (o_instr_valid || o_pass || o_error_exit || o_halt);
  endsequence
  a_take_drop: assert property (s_take |=> !o_word_ready) else $error("ready kept");
  a_first_answer: assert property (s_take |-> s_answer) else $error("no result");
  a_hold_fields: assert property (o_instr_valid && !i_issue_ready && !i_branch_taken
    |=> o_instr_valid && $stable(o_k18) && $stable(o_parcel)) else $error("not held");
  a_issue_gap: assert property (o_instr_valid && i_issue_ready |=> !o_instr_valid)
    else $error("no gap");
  a_four_at_zero: assert property (o_instr_valid && o_length == 3'h4 |-> o_parcel == 2'h0)
    else $error("four parcels late");
  a_len_legal: assert property (o_instr_valid |-> o_length inside {3'h1, 3'h2, 3'h4})
    else $error("bad length");
  a_jk_count: assert property (o_instr_valid |-> o_shift_or_mask_count == {o_j, o_k})
    else $error("count mismatch");
  a_k_field: assert property (o_instr_valid |-> (o_length == 3'h1) ? o_k18 == 18'h0
    : o_k18[17:15] == o_k) else $error("bad operand field");
  a_halt_sticky: assert property (o_halt |=> o_halt && !o_instr_valid)
    else $error("halt lost");
  a_branch_drop: assert property (i_branch_taken && o_instr_valid
    |=> !o_instr_valid && o_word_ready) else $error("branch kept word");
  a_error_ready: assert property (o_error_exit |-> ##[0:1] o_word_ready)
    else $error("no refetch");
endmodule

// ===== testbench/cpd_decoder_tb.sv
// Bench for the parcel decoder: one task per scenario, fetch model, bind.
// Assumes results two edges after a word is taken, one valid cycle each.
`timescale 1ns/1ps
module cpd_decoder_tb;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic wide = 1'b1;
  logic ejs = 1'b0;
  logic brn = 1'b0;
  logic rdy = 1'b1;
  logic wr_en = 1'b0;
  logic [1:0] wr_set = 2'h3;
  logic [2:0] wr_addr = 3'h0;
  logic [59:0] wr_data = 60'h0;
  logic wvld, wrdy, ivld, fixed, pass, err, halt;
  logic [59:0] word, xj, xk;
  logic [5:0] op6, cnt;
  logic [8:0] op9;
  logic [2:0] oi, oj, ok, len;
  logic [17:0] k18, aj, bj;
  logic [1:0] par;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  cpd_fetch_model cpd_fetch_model_inst (.i_clk(i_clk), .i_word_ready(wrdy),
    .o_word_valid(wvld), .o_word(word));
  cpd_decoder cpd_decoder_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_wide_variant(wide),
    .i_exchange_jump_enable_switch(ejs), .i_word_valid(wvld), .i_word(word),
    .i_branch_taken(brn), .i_issue_ready(rdy), .i_wr_en(wr_en), .i_wr_set(wr_set),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_word_ready(wrdy), .o_instr_valid(ivld),
    .o_opcode_six_bit(op6), .o_opcode_nine_bit(op9), .o_i(oi), .o_j(oj), .o_k(ok),
    .o_shift_or_mask_count(cnt), .o_k18(k18), .o_length(len), .o_parcel(par),
    .o_fixed_time(fixed), .o_pass(pass), .o_error_exit(err), .o_halt(halt),
    .o_aj_data(aj), .o_bj_data(bj), .o_xj_data(xj), .o_xk_data(xk));
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  // Hang guard: the run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [59:0] g, input logic [59:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [14:0] pc(input logic [59:0] w, input int n);
    pc = w[59-15*n -: 15];
  endfunction
  // Sampled at the falling edge, where the one valid cycle has settled
  task automatic expect_instr(input logic [59:0] w, input int p, input logic [2:0] l,
      input logic f);
    logic [14:0] pp;
    logic [14:0] nx;
    int t;
    pp = pc(w, p);
    nx = (p == 3) ? 15'h0 : pc(w, p + 1);
    t = 0;
    do begin
      @(negedge i_clk);
      t++;
    end while (ivld !== 1'b1 && t < 20);
    cmp({op9, op6, oi, oj, ok}, {pp[14:6], pp[14:9], pp[8:0]});
    cmp(k18, (l == 3'h1) ? 18'h0 : {pp[2:0], nx});
    cmp({len, par, fixed}, {l, p[1:0], f});
  endtask
  task automatic tally(input int n, output int np, output int ne, output int nv);
    np = 0;
    ne = 0;
    nv = 0;
    repeat (n) begin
      @(negedge i_clk);
      np += (pass === 1'b1);
      ne += (err === 1'b1);
      nv += (ivld === 1'b1);
    end
  endtask
  // Switches pass a synchroniser, so they settle well before the next word
  task automatic mode(input logic w, input logic e);
    @(posedge i_clk);
    wide <= w;
    ejs <= e;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [59:0] d);
    @(posedge i_clk);
    wr_en <= 1'b1;
    wr_set <= s;
    wr_addr <= a;
    wr_data <= d;
    @(posedge i_clk);
    wr_en <= 1'b0;
  endtask
  task automatic t_formats;
    logic [59:0] w;
    w = {15'o10123, 15'o11456, 15'o12701, 15'o17777};
    cpd_fetch_model_inst.push(w);
    for (int p = 0; p < 4; p++) expect_instr(w, p, 3'h1, 1'b1);
    w = {15'o51234, 15'o12345, 15'o13777, 15'o20017};
    cpd_fetch_model_inst.push(w);
    expect_instr(w, 0, 3'h2, 1'b0);
    expect_instr(w, 2, 3'h1, 1'b1);
    expect_instr(w, 3, 3'h1, 1'b1);
    w = {15'o46412, 15'o76543, 15'o21012, 15'o33333};
    cpd_fetch_model_inst.push(w);
    expect_instr(w, 0, 3'h4, 1'b1);
    $display("format test done");
  endtask
  task automatic t_pass;
    int np, ne, nv;
    cpd_fetch_model_inst.push({15'o46012, 15'o46377, 15'o61023, 15'o34567});
    tally(16, np, ne, nv);
    cmp({np[3:0], nv[3:0]}, {4'h3, 4'h0});
    mode(1'b0, 1'b0);
    cpd_fetch_model_inst.push({15'o46777, 15'o10123, 15'o11456, 15'o51234});
    expect_instr({15'o46777, 15'o10123, 15'o11456, 15'o51234}, 1, 3'h1, 1'b1);
    expect_instr({15'o46777, 15'o10123, 15'o11456, 15'o51234}, 2, 3'h1, 1'b1);
    expect_instr({15'o46777, 15'o10123, 15'o11456, 15'o51234}, 3, 3'h2, 1'b0);
    $display("pass and compact test done");
  endtask
  task automatic t_branch;
    logic [59:0] w;
    w = {15'o12222, 15'o13333, 15'o14444, 15'o15555};
    mode(1'b1, 1'b0);
    rdy <= 1'b0;
    cpd_fetch_model_inst.push({15'o10111, 15'o11222, 15'o12333, 15'o13444});
    cpd_fetch_model_inst.push(w);
    expect_instr({15'o10111, 15'o11222, 15'o12333, 15'o13444}, 0, 3'h1, 1'b1);
    repeat (3) @(posedge i_clk);
    brn <= 1'b1;
    @(posedge i_clk);
    brn <= 1'b0;
    rdy <= 1'b1;
    for (int p = 0; p < 4; p++) expect_instr(w, p, 3'h1, 1'b1);
    $display("branch test done");
  endtask
  task automatic t_regs;
    logic [59:0] w;
    w = {15'o10035, 15'o10005, 15'o10005, 15'o10005};
    wr(2'h0, 3'h3, 60'h12345);
    wr(2'h1, 3'h3, 60'h3abcd);
    wr(2'h1, 3'h0, 60'h3ffff);
    wr(2'h2, 3'h5, 60'h123456789abcdef);
    wr(2'h2, 3'h3, 60'hfedcba987654321);
    cpd_fetch_model_inst.push(w);
    expect_instr(w, 0, 3'h1, 1'b1);
    cmp({aj, bj}, {18'h12345, 18'h3abcd});
    cmp(xk, 60'h123456789abcdef);
    cmp(xj, 60'hfedcba987654321);
    expect_instr(w, 1, 3'h1, 1'b1);
    cmp(bj, 60'h0);
    expect_instr(w, 2, 3'h1, 1'b1);
    expect_instr(w, 3, 3'h1, 1'b1);
    $display("register test done");
  endtask
  task automatic t_zero(input logic w, input logic e, input logic h);
    int np, ne, nv;
    mode(w, e);
    cpd_fetch_model_inst.push({15'o10123, 15'o00777, 15'o12345, 15'o13456});
    expect_instr({15'o10123, 15'o00777, 15'o12345, 15'o13456}, 0, 3'h1, 1'b1);
    tally(12, np, ne, nv);
    cmp({ne[3:0], nv[3:0], halt}, {h ? 4'h0 : 4'h1, 4'h0, h});
    $display("zero opcode test done");
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    t_formats();
    t_pass();
    t_branch();
    t_regs();
    t_zero(1'b0, 1'b0, 1'b0);
    t_zero(1'b1, 1'b1, 1'b0);
    t_zero(1'b1, 1'b0, 1'b1);
    stop_test();
  end
endmodule
bind cpd_decoder cpd_checker cpd_checker_inst (.i_clk, .i_arst_n, .i_word_valid,
  .i_branch_taken, .i_issue_ready, .o_word_ready, .o_instr_valid, .o_j, .o_k,
  .o_shift_or_mask_count, .o_k18, .o_length, .o_parcel, .o_pass, .o_error_exit, .o_halt);
